// ===== design/mhp_map.svh
/*
  constants for the modem host register port: index widths, register counts,
  reserved indices, reset values and host recovery gaps.
  assumes inclusion by bare name from design files only.
*/
`ifndef MHP_MAP_SVH
`define MHP_MAP_SVH

`define MHP_IDX_W 5
`define MHP_DATA_W 8
`define MHP_NUM_REGS 32
`define MHP_IRQ_STAT_IDX 5'h1E
`define MHP_IRQ_EN_IDX 5'h1F
`define MHP_REG_RESET 8'h00
`define MHP_IRQ_EN_RESET 8'h00
`define MHP_SYNC_STAGES 2
`define MHP_WR_GAP_DSP_OUTPUT_CLOCK 4
`define MHP_RD_GAP_DSP_OUTPUT_CLOCK 2

`endif

// ===== design/mhp_pkg.sv
/*
  types for the modem host register port.
  assumes mhp_map.svh is visible on the include path.
*/
`include "mhp_map.svh"

package mhp_pkg;
  typedef logic [`MHP_IDX_W-1:0] mhp_idx_t;
  typedef logic [`MHP_DATA_W-1:0] mhp_byte_t;
  typedef enum logic [1:0] {
    MHP_IDLE  = 2'b00,
    MHP_READ  = 2'b01,
    MHP_WRITE = 2'b10
  } mhp_state_e;
endpackage

// ===== design/mhp_sync.sv
/*
  multi-stage synchroniser for a bundle of host pins.
  assumes a single clock; only the last stage is read outside.
*/
`timescale 1ns/1ps
`default_nettype none

module mhp_sync #(
  parameter int WIDTH = 1,
  parameter int STAGES = 2,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage_q [STAGES];

  if (STAGES < 2) begin : g_bad_stages
    $error("mhp_sync needs at least two stages");
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_q[i] <= INIT;
      end
    end else begin
      stage_q[0] <= d;
      for (int i = 1; i < STAGES; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign q = stage_q[STAGES-1];
endmodule

`default_nettype wire

// ===== design/mhp_host_port.sv
/*
  host-side parallel port of a modem signal processor: 32 byte-wide
  interface registers reached by register select, chip select, read and
  write strobes, plus an open-drain interrupt request.
  assumes the data and interrupt wires are resolved outside from the
  enables, the pull-up sits on the board, and the core side is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mhp_map.svh"

module mhp_host_port
  import mhp_pkg::*;
#(
  parameter int SYNC_STAGES = `MHP_SYNC_STAGES
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic [`MHP_IDX_W-1:0] REGISTER_SELECT_LINES,
  input wire logic [`MHP_DATA_W-1:0] HOST_DATA_LINES_IN,
  output logic [`MHP_DATA_W-1:0] HOST_DATA_LINES_OUT,
  output logic HOST_DATA_LINES_OE,
  output logic HOST_INTERRUPT_LINE_OUT,
  output logic HOST_INTERRUPT_LINE_OE,
  input wire logic CORE_WE,
  input wire logic [`MHP_IDX_W-1:0] CORE_ADDR,
  input wire logic [`MHP_DATA_W-1:0] CORE_WDATA,
  output logic [`MHP_DATA_W-1:0] CORE_RDATA,
  input wire logic [`MHP_DATA_W-1:0] CORE_EVENT,
  output logic HOST_WR_STB,
  output logic [`MHP_IDX_W-1:0] HOST_WR_ADDR
);
  localparam int PIN_W = 3 + `MHP_IDX_W + `MHP_DATA_W;

  if (SYNC_STAGES < 2 || SYNC_STAGES > 8) begin : g_bad_stages
    $error("mhp_host_port: SYNC_STAGES must be 2..8");
  end

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  mhp_idx_t sel_s;
  mhp_byte_t data_s;

  mhp_state_e state_q;
  mhp_idx_t wr_idx_q;
  mhp_byte_t wr_data_q;
  mhp_byte_t regs_q [`MHP_NUM_REGS];
  mhp_byte_t irq_stat_q;
  mhp_byte_t irq_en_q;
  mhp_byte_t dout_q;
  logic doe_q;
  logic irq_oe_q;
  logic irq_out_q;
  mhp_byte_t core_rdata_q;
  logic host_wr_stb_q;
  mhp_idx_t host_wr_addr_q;
  logic commit;
  logic host_stat_wr;

  assign pins_raw = {CS_N, RD_N, WR_N, REGISTER_SELECT_LINES, HOST_DATA_LINES_IN};

  mhp_sync #(
    .WIDTH(PIN_W),
    .STAGES(SYNC_STAGES),
    .INIT({3'b111, {(`MHP_IDX_W + `MHP_DATA_W){1'b0}}})
  ) u_pin_sync (
    .clk(CLK),
    .rst_b(RST_B),
    .d(pins_raw),
    .q(pins_s)
  );

  assign cs_n_s = pins_s[PIN_W-1];
  assign rd_n_s = pins_s[PIN_W-2];
  assign wr_n_s = pins_s[PIN_W-3];
  assign sel_s = pins_s[`MHP_DATA_W +: `MHP_IDX_W];
  assign data_s = pins_s[`MHP_DATA_W-1:0];

  // register read decode
  function automatic mhp_byte_t reg_read(input mhp_idx_t idx);
    mhp_byte_t r;
    r = regs_q[idx];
    if (idx == `MHP_IRQ_STAT_IDX) begin
      r = irq_stat_q;
    end else if (idx == `MHP_IRQ_EN_IDX) begin
      r = irq_en_q;
    end
    return r;
  endfunction

  assign commit = (state_q == MHP_WRITE) && (wr_n_s || cs_n_s);
  assign host_stat_wr = commit && (wr_idx_q == `MHP_IRQ_STAT_IDX);

  // access sequencer
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      state_q <= MHP_IDLE;
    end else begin
      case (state_q)
        MHP_IDLE: begin
          if (!cs_n_s && !rd_n_s) begin
            state_q <= MHP_READ;
          end else if (!cs_n_s && !wr_n_s) begin
            state_q <= MHP_WRITE;
          end
        end
        MHP_READ: begin
          if (rd_n_s || cs_n_s) begin
            state_q <= MHP_IDLE;
          end
        end
        MHP_WRITE: begin
          if (wr_n_s || cs_n_s) begin
            state_q <= MHP_IDLE;
          end
        end
        default: begin
          state_q <= MHP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      wr_idx_q <= '0;
      wr_data_q <= `MHP_REG_RESET;
    end else if (!cs_n_s && !wr_n_s && state_q != MHP_READ) begin
      wr_idx_q <= sel_s;
      wr_data_q <= data_s;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      for (int i = 0; i < `MHP_NUM_REGS; i++) begin
        regs_q[i] <= `MHP_REG_RESET;
      end
    end else if (commit) begin
      regs_q[wr_idx_q] <= wr_data_q;
    end else if (CORE_WE) begin
      regs_q[CORE_ADDR] <= CORE_WDATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      irq_en_q <= `MHP_IRQ_EN_RESET;
    end else if (commit && wr_idx_q == `MHP_IRQ_EN_IDX) begin
      irq_en_q <= wr_data_q;
    end
  end

  generate
    for (genvar b = 0; b < `MHP_DATA_W; b++) begin : g_stat
      always_ff @(posedge CLK) begin
        if (!RST_B) begin
          irq_stat_q[b] <= 1'b0;
        end else if (CORE_EVENT[b]) begin
          irq_stat_q[b] <= 1'b1;
        end else if (host_stat_wr && wr_data_q[b]) begin
          irq_stat_q[b] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      irq_oe_q <= 1'b0;
      irq_out_q <= 1'b0;
    end else begin
      irq_oe_q <= |(irq_stat_q & irq_en_q);
      irq_out_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      dout_q <= `MHP_REG_RESET;
    end else if (state_q == MHP_IDLE && !cs_n_s && !rd_n_s) begin
      dout_q <= reg_read(sel_s);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      doe_q <= 1'b0;
    end else begin
      doe_q <= !cs_n_s && !rd_n_s && state_q != MHP_WRITE;
    end
  end

  // core side read and write notice
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      core_rdata_q <= `MHP_REG_RESET;
      host_wr_stb_q <= 1'b0;
      host_wr_addr_q <= '0;
    end else begin
      core_rdata_q <= reg_read(CORE_ADDR);
      host_wr_stb_q <= commit;
      if (commit) begin
        host_wr_addr_q <= wr_idx_q;
      end
    end
  end

  assign HOST_DATA_LINES_OUT = dout_q;
  assign HOST_DATA_LINES_OE = doe_q;
  assign HOST_INTERRUPT_LINE_OUT = irq_out_q;
  assign HOST_INTERRUPT_LINE_OE = irq_oe_q;
  assign CORE_RDATA = core_rdata_q;
  assign HOST_WR_STB = host_wr_stb_q;
  assign HOST_WR_ADDR = host_wr_addr_q;
endmodule

`default_nettype wire

// ===== dv/mhp_host_port_asserts.sv
/* assertions on the host port pins.
   bound to mhp_host_port; one clock. */
`timescale 1ns/1ps
`default_nettype none
module mhp_host_port_asserts (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic [4:0] REGISTER_SELECT_LINES,
  input wire logic HOST_DATA_LINES_OE,
  input wire logic HOST_INTERRUPT_LINE_OUT,
  input wire logic HOST_INTERRUPT_LINE_OE,
  input wire logic [7:0] CORE_EVENT,
  input wire logic HOST_WR_STB,
  input wire logic [4:0] HOST_WR_ADDR
);
  logic ev_q;
  always_ff @(posedge CLK) begin
    if (!RST_B) ev_q <= 1'b0;
    else if (|CORE_EVENT) ev_q <= 1'b1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  sequence rd_s;
    (!CS_N && !RD_N && WR_N) [*3];
  endsequence
  sequence wr_s;
    (!CS_N && !WR_N && RD_N) [*2] ##1 WR_N [*3];
  endsequence
  a_irq_open_drain: assert property (!HOST_INTERRUPT_LINE_OUT)
    else $error("irq out high");
  a_irq_needs_event: assert property (!ev_q |-> !HOST_INTERRUPT_LINE_OE)
    else $error("irq with no event");
  a_read_drives: assert property (rd_s |=> HOST_DATA_LINES_OE)
    else $error("read not driven");
  a_idle_release: assert property (CS_N [*4] |-> !HOST_DATA_LINES_OE)
    else $error("idle bus driven");
  a_oe_holds: assert property (
    $fell(HOST_DATA_LINES_OE) |-> $past(RD_N, 3) || $past(CS_N, 3))
    else $error("bus released early");
  a_wr_single: assert property (HOST_WR_STB |=> !HOST_WR_STB)
    else $error("write pulse too long");
  a_wr_commit: assert property (
    wr_s |=> HOST_WR_STB && HOST_WR_ADDR == $past(REGISTER_SELECT_LINES, 4))
    else $error("write not committed");
endmodule
bind mhp_host_port mhp_host_port_asserts u_chk (.CLK, .RST_B, .CS_N, .RD_N, .WR_N,
  .REGISTER_SELECT_LINES, .HOST_DATA_LINES_OE, .HOST_INTERRUPT_LINE_OUT,
  .HOST_INTERRUPT_LINE_OE, .CORE_EVENT, .HOST_WR_STB, .HOST_WR_ADDR);
`default_nettype wire

// ===== dv/mhp_host_model.sv
/* host processor model on the byte port.
   assumes a pull-up on the irq wire, none on data. */
`timescale 1ns/1ps
`default_nettype none
module mhp_host_model (
  input wire logic clk,
  output var logic cs_n = 1'b1,
  output var logic rd_n = 1'b1,
  output var logic wr_n = 1'b1,
  output var logic [4:0] sel = 5'h00,
  output logic [7:0] data,
  input wire logic [7:0] dev_out,
  input wire logic dev_oe,
  input wire logic irq_oe,
  output logic irq
);
  logic [7:0] hd = 8'h00;
  logic [7:0] last = 8'h00;
  logic hoe = 1'b0;
  assign data = dev_oe ? dev_out : (hoe ? hd : ~last);
  assign irq = !irq_oe;
  always @(posedge clk) last <= data;
  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    @(posedge clk) #1;
    sel = i;
    hd = d;
    hoe = 1'b1;
    cs_n = 1'b0;
    wr_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    wr_n = 1'b1;
    cs_n = 1'b1;
    hoe = 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] i, output logic [7:0] d);
    int n;
    @(posedge clk) #1;
    sel = i;
    cs_n = 1'b0;
    rd_n = 1'b0;
    for (n = 0; n < 8 && dev_oe !== 1'b1; n++) @(posedge clk) #1;
    @(posedge clk);
    d = data;
    #1;
    rd_n = 1'b1;
    cs_n = 1'b1;
    repeat (3) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== dv/mhp_host_port_tb.sv
/* self-checking bench for the host port.
   assumes host model and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module mhp_host_port_tb
  import mhp_pkg::*;
;
  int failures = 0;
  int n_checks = 0;
  int stb_cnt = 0;
  logic clk, rst_b, cs_n, rd_n, wr_n, doe, iout, ioe, stb, irq;
  mhp_idx_t addr, sel, waddr;
  mhp_byte_t ev, crd, dout, data;
  mhp_host_port uut (.CLK(clk), .RST_B(rst_b), .CS_N(cs_n), .RD_N(rd_n),
    .WR_N(wr_n), .REGISTER_SELECT_LINES(sel), .HOST_DATA_LINES_IN(data),
    .HOST_DATA_LINES_OUT(dout), .HOST_DATA_LINES_OE(doe),
    .HOST_INTERRUPT_LINE_OUT(iout), .HOST_INTERRUPT_LINE_OE(ioe),
    .CORE_WE(1'b0), .CORE_ADDR(addr), .CORE_WDATA(8'h00), .CORE_RDATA(crd),
    .CORE_EVENT(ev), .HOST_WR_STB(stb), .HOST_WR_ADDR(waddr));
  mhp_host_model host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .sel(sel), .data(data), .dev_out(dout), .dev_oe(doe), .irq_oe(ioe), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (stb === 1'b1) stb_cnt++;
  task automatic chk(input string nm, input mhp_byte_t e, input mhp_byte_t g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results;
    if (failures == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_rw;
    mhp_byte_t v;
    for (int i = 0; i < 30; i++) host.wr(5'(i), 8'(i) ^ 8'ha5);
    settle;
    chk("wr_pulses", 8'h1e, 8'(stb_cnt));
    chk("wr_addr", 8'h1d, 8'(waddr));
    for (int i = 29; i >= 0; i--) begin
      host.rd(5'(i), v);
      chk("rd_data", 8'(i) ^ 8'ha5, v);
    end
    addr = 5'h03;
    settle;
    chk("core_rdata", 8'ha6, crd);
  endtask
  task automatic t_irq;
    mhp_byte_t v;
    ev = 8'h01;
    @(posedge clk) #1;
    ev = 8'h00;
    settle;
    chk("irq_masked", 8'h01, {7'h0, irq});
    host.rd(5'h1e, v);
    chk("status", 8'h01, v);
    host.wr(5'h1f, 8'h01);
    settle;
    chk("irq_low", 8'h00, {7'h0, irq});
    for (int n = 0; n < 4 && irq !== 1'b1; n++) host.wr(5'h1e, 8'h01);
    settle;
    chk("irq_high", 8'h01, {7'h0, irq});
  endtask
  initial begin
    rst_b = 1'b0;
    addr = 5'h00;
    ev = 8'h00;
    repeat (5) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_rw;
    t_irq;
    results;
  end
  initial begin
    #40000;
    failures++;
    results;
  end
endmodule
`default_nettype wire
